// ### src/sdm_spi_core.sv
// Serial peripheral data path, buffers, flags and duplex modes
`timescale 1ns/1ps
module sdm_spi_core #(
	parameter int HALF_DIV = sdm_pkg::SCK_HALF_DIV
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// Serial clock pin
	input  wire logic        SCK_IN,
	output logic             SCK_OUT,
	output logic             SCK_OE,
	// Master-out data pin
	input  wire logic        MOSI_IN,
	output logic             MOSI_OUT,
	output logic             MOSI_OE,
	// Master-in data pin
	input  wire logic        MISO_IN,
	output logic             MISO_OUT,
	output logic             MISO_OE,
	// Slave select and event request
	input  wire logic        SLAVE_SELECT_N,
	output logic             IRQ_REQ
);
	import sdm_pkg::*;

	logic [CTL_WIDTH-1:0] ctrl;
	logic        peripheral_enable, master_sel, single_line_mode;
	logic        single_line_output_dir, receive_only_select;
	logic        soft_select_mgmt, soft_select_level;
	logic        tx_empty_irq_enable, rx_full_irq_enable;
	logic [7:0]  tx_buf, rx_buf, sreg;
	logic        tx_empty_flag, rx_not_empty_flag, overrun_flag;
	logic        busy_flag;
	logic [2:0]  bit_cnt;
	logic        sample, sck_lvl, sck_prev;
	logic        s_mid, s_guard;
	logic [1:0]  busy_wait;
	sdm_mstate_t mstate;
	logic        sck_s, mosi_s, miso_s, nss_s;
	logic        tick;
	logic        ctrl_wr, data_wr, data_rd, stat_rd;
	logic        tx_en, rx_en, cont_mode, din, selected, s_act;
	logic        s_rise, s_fall, m_rise, m_fall, rise, fall;
	logic        start_m, cont_m, word_end, load, take_tx, cap;
	logic [7:0]  cap_word;

	// Control fields
	assign peripheral_enable      = ctrl[CTL_ENABLE];
	assign master_sel             = ctrl[CTL_MASTER];
	assign single_line_mode       = ctrl[CTL_SINGLE];
	assign single_line_output_dir = ctrl[CTL_OUTDIR];
	assign receive_only_select    = ctrl[CTL_RECEIVE_ONLY_SELECT];
	assign soft_select_mgmt       = ctrl[CTL_SOFTSEL];
	assign soft_select_level      = ctrl[CTL_SELLVL];
	assign tx_empty_irq_enable    = ctrl[CTL_TX_EMPTY_IRQ_ENABLE];
	assign rx_full_irq_enable     = ctrl[CTL_RX_FULL_IRQ_ENABLE];

	// Register access decode
	assign ctrl_wr = REG_WR && (REG_ADDR == OFS_CTRL);
	assign data_wr = REG_WR && (REG_ADDR == OFS_DATA);
	assign data_rd = REG_RD && (REG_ADDR == OFS_DATA);
	assign stat_rd = REG_RD && (REG_ADDR == OFS_STATUS);

	// Pins come from another domain, two flops before any use
	sdm_sync2 #(
		.W(4)
	) u_sync (
		.clk  (REF_CLK),
		.rst_n(RESETN),
		.d    ({SCK_IN, MOSI_IN, MISO_IN, SLAVE_SELECT_N}),
		.q    ({sck_s, mosi_s, miso_s, nss_s})
	);

	// Master bit-rate enable, runs only inside a transfer
	sdm_tick_div #(
		.DIV(HALF_DIV)
	) u_div (
		.clk  (REF_CLK),
		.rst_n(RESETN),
		.run  (mstate == M_SHIFT),
		.tick (tick)
	);

	// Mode decode: what each configuration sends and receives
	assign tx_en = single_line_mode ? single_line_output_dir
	                                : !receive_only_select;
	assign rx_en = single_line_mode ? !single_line_output_dir
	                                : 1'b1;
	assign cont_mode = single_line_mode ? !single_line_output_dir
	                                    : receive_only_select;
	// Data source: one shared wire in single-line mode
	assign din = (master_sel ^ single_line_mode) ? miso_s
	                                             : mosi_s;

	// Slave selection by pin or software level
	assign selected = soft_select_mgmt ? !soft_select_level
	                                   : !nss_s;
	assign s_act    = !master_sel && peripheral_enable && selected;
	assign s_rise   = sck_s && !sck_prev;
	assign s_fall   = !sck_s && sck_prev;

	// Edge events of whichever role is active
	assign m_rise = (mstate == M_SHIFT) && tick && !sck_lvl;
	assign m_fall = (mstate == M_SHIFT) && tick && sck_lvl;
	assign rise   = master_sel ? m_rise : (s_act && s_rise);
	assign fall   = master_sel ? m_fall : (s_act && s_fall);
	assign word_end = fall && (bit_cnt == 3'(WORD_BITS - 1));

	// Master start: write-driven after the busy delay, or free-running
	assign start_m = master_sel && peripheral_enable
	              && (mstate == M_IDLE)
	              && (cont_mode
	               || (tx_en && !tx_empty_flag
	                   && busy_wait == 2'b00));
	// Master carries on without a gap while work remains
	assign cont_m = peripheral_enable
	             && (cont_mode || (tx_en && !tx_empty_flag));

	// Moves from Tx buffer to shift register
	assign load = master_sel ? (start_m || (m_fall && word_end && cont_m))
	                         : (s_act && s_rise && !s_mid);
	assign take_tx  = load && tx_en && !tx_empty_flag;
	assign cap      = rise && rx_en
	               && (bit_cnt == 3'(WORD_BITS - 1));
	assign cap_word = {sreg[6:0], din};

	// Sampled serial clock for slave edge detection
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			sck_prev <= 1'b0;
		else
			sck_prev <= sck_s;
	end

	// Control register
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			ctrl <= CTL_RESET;
		else if (ctrl_wr)
			ctrl <= REG_WDATA[CTL_WIDTH-1:0];
	end

	// Write always lands in the Tx buffer, overwriting any old word
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			tx_buf <= 8'h00;
		else if (data_wr)
			tx_buf <= REG_WDATA[7:0];
	end

	// Tx-empty; a write in the load cycle keeps the new word pending
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			tx_empty_flag <= 1'b1;
		else if (data_wr)
			tx_empty_flag <= 1'b0;
		else if (take_tx)
			tx_empty_flag <= 1'b1;
	end

	// Busy delay after a write, so status lags the write
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			busy_wait <= 2'b00;
		else if (data_wr)
			busy_wait <= BUSY_WAIT_LOAD;
		else if (busy_wait != 2'b00)
			busy_wait <= busy_wait - 2'b01;
	end

	// Rx buffer and Rx-not-empty; a new word beats a same-cycle read
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			rx_buf            <= 8'h00;
			rx_not_empty_flag <= 1'b0;
		end else if (cap && (!rx_not_empty_flag || data_rd)) begin
			rx_buf            <= cap_word;
			rx_not_empty_flag <= 1'b1;
		end else if (data_rd) begin
			rx_not_empty_flag <= 1'b0;
		end
	end

	// Overrun: new word lost, unread word kept; status read clears, set wins
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			overrun_flag <= 1'b0;
		else if (cap && rx_not_empty_flag && !data_rd)
			overrun_flag <= 1'b1;
		else if (stat_rd)
			overrun_flag <= 1'b0;
	end

	// Master state: stops at a word boundary, or at once when master role is cleared
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			mstate <= M_IDLE;
		else if (!master_sel)
			mstate <= M_IDLE;
		else if (start_m)
			mstate <= M_SHIFT;
		else if (m_fall && word_end && !cont_m)
			mstate <= M_IDLE;
	end

	// Master clock level, toggled by the divider ticks
	always_ff @(posedge REF_CLK) begin
		if (!RESETN || mstate == M_IDLE)
			sck_lvl <= 1'b0;
		else if (tick)
			sck_lvl <= !sck_lvl;
	end

	// Shift engine for both roles; mode 0, MSB first
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			sreg    <= 8'h00;
			bit_cnt <= 3'h0;
			sample  <= 1'b0;
		end else if (!master_sel && !s_act) begin
			bit_cnt <= 3'h0;
		end else begin
			if (rise)
				sample <= din;
			if (load && !master_sel)
				sreg <= take_tx ? tx_buf : 8'h00;
			if (load && master_sel)
				sreg <= take_tx ? tx_buf : 8'h00;
			else if (fall && !word_end)
				sreg <= {sreg[6:0], sample};
			if (fall)
				bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// Slave word tracking and the busy gap between words
	always_ff @(posedge REF_CLK) begin
		if (!RESETN || !s_act) begin
			s_mid   <= 1'b0;
			s_guard <= 1'b0;
		end else begin
			if (load)
				s_mid <= 1'b1;
			else if (word_end)
				s_mid <= 1'b0;
			if (word_end)
				s_guard <= 1'b1;
			else if (s_fall && bit_cnt == 3'h0)
				s_guard <= 1'b0;
		end
	end

	// Busy: master while shifting, slave inside a word past the gap
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			busy_flag <= 1'b0;
		else if (master_sel)
			busy_flag <= (mstate == M_SHIFT) || start_m;
		else
			busy_flag <= s_act && s_mid && !s_guard
			          && !word_end;
	end

	// Pin drivers, registered; released pins stay undriven
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			SCK_OUT  <= 1'b0;
			SCK_OE   <= 1'b0;
			MOSI_OUT <= 1'b0;
			MOSI_OE  <= 1'b0;
			MISO_OUT <= 1'b0;
			MISO_OE  <= 1'b0;
		end else begin
			SCK_OE   <= master_sel && peripheral_enable;
			SCK_OUT  <= master_sel && peripheral_enable && sck_lvl;
			MOSI_OE  <= master_sel && peripheral_enable
			         && tx_en;
			MOSI_OUT <= sreg[7];
			MISO_OE  <= s_act && tx_en;
			// Slave shows first bit before the first clock edge
			MISO_OUT <= s_mid ? sreg[7]
			                  : (!tx_empty_flag && tx_buf[7]);
		end
	end

	// Event request from flags and their enables
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			IRQ_REQ <= 1'b0;
		else
			IRQ_REQ <= (tx_empty_flag && tx_empty_irq_enable)
			        || (rx_not_empty_flag && rx_full_irq_enable);
	end

	// Register read data, valid the cycle after the strobe
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			REG_RDATA <= 32'h00000000;
		else if (REG_RD) begin
			unique case (REG_ADDR)
				OFS_CTRL:   REG_RDATA <= 32'(ctrl);
				OFS_STATUS: REG_RDATA <= 32'({overrun_flag, busy_flag,
				                rx_not_empty_flag, tx_empty_flag});
				OFS_DATA:   REG_RDATA <= {24'h000000, rx_buf};
				default:    REG_RDATA <= 32'h00000000;
			endcase
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	sequence s_idle_write;
		master_sel && peripheral_enable && mstate == M_IDLE
		&& !cont_mode && tx_en && data_wr;
	endsequence
	sequence s_busy_late;
		!busy_flag ##1 busy_flag;
	endsequence

	a_busy_after_write: assert property (
		s_idle_write ##1 (!data_wr && !ctrl_wr)[*2] |-> s_busy_late)
		else $error("busy not set two clocks after write");
	a_txe_write_clear: assert property (
		data_wr |=> !tx_empty_flag)
		else $error("tx empty not cleared by write");
	a_txe_on_load: assert property (
		take_tx && !data_wr |=> tx_empty_flag)
		else $error("tx empty not set on load");
	a_rx_not_empty_flag_on_word: assert property (
		cap && !rx_not_empty_flag |=>
			rx_not_empty_flag && rx_buf == $past(cap_word))
		else $error("received word not moved to rx buffer");
	a_rx_not_empty_flag_read_clear: assert property (
		data_rd && !cap |=> !rx_not_empty_flag)
		else $error("rx not empty kept after read");
	a_ovr_second_word: assert property (
		cap && rx_not_empty_flag && !data_rd |=> overrun_flag)
		else $error("overrun not set on unread word");
	a_receive_only_select_no_drive: assert property (
		!single_line_mode && receive_only_select && !ctrl_wr
			|=> !MOSI_OE && !MISO_OE)
		else $error("transmit pin driven in receive-only");
	a_single_dir_out: assert property (
		master_sel && peripheral_enable && single_line_mode && !ctrl_wr
			|=> MOSI_OE == $past(single_line_output_dir))
		else $error("single-line direction wrong");
	a_rx_master_run: assert property (
		master_sel && peripheral_enable && cont_mode
			&& mstate == M_IDLE |=> mstate == M_SHIFT ##1 busy_flag)
		else $error("receive-only master did not start");
	a_slave_gap_low: assert property (
		!master_sel && word_end |=> !busy_flag [*2])
		else $error("slave busy not dropped between words");
endmodule : sdm_spi_core

// ### src/sdm_pkg.sv
// Constants for the serial peripheral duplex-mode block
package sdm_pkg;
	// Register offsets, byte addresses
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DATA   = 8'h08;
	// Control register fields
	localparam int CTL_ENABLE  = 0;
	localparam int CTL_MASTER  = 1;
	localparam int CTL_SINGLE  = 2;
	localparam int CTL_OUTDIR  = 3;
	localparam int CTL_RECEIVE_ONLY_SELECT  = 4;
	localparam int CTL_SOFTSEL = 5;
	localparam int CTL_SELLVL  = 6;
	localparam int CTL_TX_EMPTY_IRQ_ENABLE   = 7;
	localparam int CTL_RX_FULL_IRQ_ENABLE  = 8;
	localparam int CTL_WIDTH   = 9;
	localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h000;
	// Status register fields
	localparam int STS_TXE  = 0;
	localparam int STS_RX_NOT_EMPTY_FLAG = 1;
	localparam int STS_BUSY = 2;
	localparam int STS_OVR  = 3;
	// Word and timing figures
	localparam int WORD_BITS = 8;
	localparam int BUSY_DELAY = 2;
	localparam int SCK_HALF_DIV = 4;
	localparam logic [1:0] BUSY_WAIT_LOAD = 2'(BUSY_DELAY - 1);
	// Master engine states
	typedef enum logic [0:0] {
		M_IDLE  = 1'b0,
		M_SHIFT = 1'b1
	} sdm_mstate_t;
endpackage : sdm_pkg

// ### src/sdm_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sdm_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Asynchronous in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : sdm_sync2

// ### src/sdm_tick_div.sv
// Half-period tick divider for the master serial clock
`timescale 1ns/1ps
module sdm_tick_div #(
	parameter int DIV = 4
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Run gate and enable pulse
	input  wire logic run,
	output logic      tick
);
	logic [15:0] cnt;

	// Restarts at zero so first edge is a full half period away
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			cnt  <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == 16'(DIV - 1)) begin
			cnt  <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : sdm_tick_div

// ### bench/sdm_peer.sv
// Behavioural serial peer: mode 0 slave or frame-making master
`timescale 1ns/1ps
module sdm_peer (
	// Resolved pin levels
	input  wire logic sck_line,
	input  wire logic mosi_line,
	input  wire logic miso_line,
	// Peer drive values and select
	output logic      sck_drv,
	output logic      mosi_drv,
	output logic      miso_drv,
	output logic      sel_n
);
	logic       is_master;
	logic       mo_bit;
	logic       junk;
	logic       on_mosi;
	logic [7:0] reply;
	logic [7:0] rx_sr;
	// Idle: serial clock low and still, deselected
	initial begin
		is_master = 1'b0;
		mo_bit    = 1'b0;
		junk      = 1'b0;
		on_mosi   = 1'b0;
		reply     = 8'h00;
		rx_sr     = 8'h00;
		sck_drv   = 1'b0;
		sel_n     = 1'b1;
	end
	// Released lines toggle so a stale level never passes for data
	always #7 junk = ~junk;
	// Slave side samples on rise and rotates its reply on fall
	always @(posedge sck_line) rx_sr <= {rx_sr[6:0], mosi_line};
	always @(negedge sck_line) reply <= {reply[6:0], reply[7]};
	assign miso_drv = is_master ? junk : reply[7];
	assign mosi_drv = is_master ? mo_bit : (on_mosi ? reply[7] : junk);
	// Slave side answers on MOSI when the device owns one shared wire
	task automatic talk_on_mosi(input logic en);
		on_mosi = en;
	endtask : talk_on_mosi
	// Reply byte for the frames the device clocks
	task automatic load(input logic [7:0] b);
		reply = b;
	endtask : load
	// One master frame, 160 ns serial period, MSB first
	// Starts 1 ns off the bench edge so no pin moves on a clock edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#1;
		is_master = 1'b1;
		sel_n     = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mo_bit = tx[i];
			#80 sck_drv = 1'b1;
			rx = {rx[6:0], miso_line};
			#80 sck_drv = 1'b0;
		end
		#80 sel_n = 1'b1;
		is_master = 1'b0;
	endtask : xfer
endmodule : sdm_peer

// ### bench/sdm_spi_core_tb.sv
// Self-checking bench for the serial duplex-mode core
`timescale 1ns/1ps
module sdm_spi_core_tb;
	import sdm_pkg::*;
	localparam int HALF  = 4;
	localparam int LIMIT = 20000;
	// Design ports
	logic        REF_CLK, RESETN, REG_WR, REG_RD;
	logic [7:0]  REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA;
	logic        SCK_OUT, SCK_OE, MOSI_OUT, MOSI_OE;
	logic        MISO_OUT, MISO_OE, IRQ_REQ;
	// Peer drives and resolved pin levels
	logic        p_sck, p_mosi, p_miso, p_sel_n;
	wire logic   sck_l  = SCK_OE  ? SCK_OUT  : p_sck;
	wire logic   mosi_l = MOSI_OE ? MOSI_OUT : p_mosi;
	wire logic   miso_l = MISO_OE ? MISO_OUT : p_miso;
	// Bench state
	int          miscompares, n_tests, cycles;
	logic [31:0] rv;
	logic [7:0]  pb;
	logic        watch, seen;

	sdm_spi_core #(.HALF_DIV(HALF)) i_sdm_spi_core (
		.REF_CLK(REF_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .SCK_IN(sck_l), .SCK_OUT(SCK_OUT),
		.SCK_OE(SCK_OE), .MOSI_IN(mosi_l), .MOSI_OUT(MOSI_OUT),
		.MOSI_OE(MOSI_OE), .MISO_IN(miso_l), .MISO_OUT(MISO_OUT),
		.MISO_OE(MISO_OE), .SLAVE_SELECT_N(p_sel_n), .IRQ_REQ(IRQ_REQ));
	sdm_peer i_sdm_peer (
		.sck_line(sck_l), .mosi_line(mosi_l), .miso_line(miso_l),
		.sck_drv(p_sck), .mosi_drv(p_mosi), .miso_drv(p_miso),
		.sel_n(p_sel_n));

	always #2.5 REF_CLK = ~REF_CLK;
	// Any MISO drive while watched is remembered
	always @(posedge REF_CLK) if (watch && MISO_OE) seen <= 1'b1;
	// Hang guard
	always @(posedge REF_CLK) begin
		cycles = cycles + 1;
		if (cycles >= LIMIT) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	// Bus cycles: entered just after an edge, leave one idle cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
		@(posedge REF_CLK);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		@(posedge REF_CLK);
		rv = REG_RDATA;
	endtask : rd
	// Poll one status bit under a bounded count, never on a stale read
	task automatic waitf(input int b, input logic v);
		rd(OFS_STATUS);
		for (int i = 0; i < 400 && rv[b] !== v; i++)
			rd(OFS_STATUS);
		chk({31'h0, rv[b]}, {31'h0, v});
	endtask : waitf

	task automatic t_reset();
		rd(OFS_STATUS);
		chk(rv, 32'h1);
		rd(OFS_CTRL);
		chk(rv, 32'h0);
		rd(8'hfc);
		chk(rv, 32'h0);
	endtask : t_reset
	task automatic t_master_fd();
		i_sdm_peer.load(8'ha5);
		wr(OFS_CTRL, 32'h083);
		rd(OFS_CTRL);
		chk(rv, 32'h083);
		chk({31'h0, IRQ_REQ}, 32'h1);
		// Data write, then status read in the very next cycle
		REG_ADDR  <= OFS_DATA;
		REG_WDATA <= 32'h3c;
		REG_WR    <= 1'b1;
		@(posedge REF_CLK);
		REG_WR   <= 1'b0;
		REG_ADDR <= OFS_STATUS;
		REG_RD   <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		@(posedge REF_CLK);
		chk(REG_RDATA & 32'h4, 32'h0);
		rv = REG_RDATA;
		waitf(STS_BUSY, 1'b1);
		waitf(STS_TXE, 1'b1);
		wr(OFS_DATA, 32'hc6);
		waitf(STS_RX_NOT_EMPTY_FLAG, 1'b1);
		rd(OFS_DATA);
		chk(rv, 32'ha5);
		waitf(STS_RX_NOT_EMPTY_FLAG, 1'b1);
		rd(OFS_DATA);
		waitf(STS_BUSY, 1'b0);
		chk({24'h0, i_sdm_peer.rx_sr}, 32'hc6);
	endtask : t_master_fd
	task automatic t_overrun();
		wr(OFS_CTRL, 32'h002);
		wr(OFS_DATA, 32'h11);
		wr(OFS_DATA, 32'h5e);
		wr(OFS_CTRL, 32'h003);
		waitf(STS_TXE, 1'b1);
		waitf(STS_BUSY, 1'b0);
		chk({24'h0, i_sdm_peer.rx_sr}, 32'h5e);
		wr(OFS_DATA, 32'h77);
		repeat (120) @(posedge REF_CLK);
		rd(OFS_STATUS);
		chk(rv & 32'hf, 32'hb);
		rd(OFS_STATUS);
		chk(rv & 32'hf, 32'h3);
		rd(OFS_DATA);
	endtask : t_overrun
	task automatic t_master_receive_only_select();
		i_sdm_peer.load(8'h5a);
		wr(OFS_CTRL, 32'h013);
		waitf(STS_RX_NOT_EMPTY_FLAG, 1'b1);
		chk({31'h0, MOSI_OE}, 32'h0);
		chk(rv & 32'h4, 32'h4);
		rd(OFS_DATA);
		chk(rv, 32'h5a);
		wr(OFS_CTRL, 32'h012);
		waitf(STS_BUSY, 1'b0);
		chk({31'h0, SCK_OE}, 32'h0);
		rd(OFS_DATA);
		rd(OFS_STATUS);
	endtask : t_master_receive_only_select
	task automatic t_single_tx();
		wr(OFS_CTRL, 32'h00f);
		wr(OFS_DATA, 32'hc3);
		waitf(STS_TXE, 1'b1);
		chk({30'h0, MOSI_OE, MISO_OE}, 32'h2);
		waitf(STS_BUSY, 1'b0);
		chk({24'h0, i_sdm_peer.rx_sr}, 32'hc3);
		chk(rv & 32'h2, 32'h0);
	endtask : t_single_tx
	task automatic t_single_rx();
		i_sdm_peer.load(8'h4b);
		i_sdm_peer.talk_on_mosi(1'b1);
		wr(OFS_CTRL, 32'h007);
		waitf(STS_RX_NOT_EMPTY_FLAG, 1'b1);
		chk({31'h0, MOSI_OE}, 32'h0);
		rd(OFS_DATA);
		chk(rv, 32'h4b);
		wr(OFS_CTRL, 32'h006);
		waitf(STS_BUSY, 1'b0);
		rd(OFS_DATA);
		rd(OFS_STATUS);
		i_sdm_peer.talk_on_mosi(1'b0);
	endtask : t_single_rx
	task automatic t_slave_fd();
		wr(OFS_CTRL, 32'h000);
		wr(OFS_DATA, 32'h96);
		wr(OFS_CTRL, 32'h001);
		i_sdm_peer.xfer(8'h69, pb);
		@(posedge REF_CLK);
		chk({24'h0, pb}, 32'h96);
		waitf(STS_RX_NOT_EMPTY_FLAG, 1'b1);
		chk(rv & 32'h1, 32'h1);
		rd(OFS_DATA);
		chk(rv, 32'h69);
	endtask : t_slave_fd
	task automatic t_slave_single();
		wr(OFS_CTRL, 32'h000);
		wr(OFS_DATA, 32'hd2);
		wr(OFS_CTRL, 32'h00d);
		i_sdm_peer.xfer(8'h00, pb);
		@(posedge REF_CLK);
		chk({24'h0, pb}, 32'hd2);
		rd(OFS_STATUS);
		chk(rv & 32'h3, 32'h1);
	endtask : t_slave_single
	task automatic t_slave_receive_only_select();
		wr(OFS_CTRL, 32'h011);
		watch = 1'b1;
		i_sdm_peer.xfer(8'h81, pb);
		@(posedge REF_CLK);
		watch = 1'b0;
		chk({31'h0, seen}, 32'h0);
		waitf(STS_RX_NOT_EMPTY_FLAG, 1'b1);
		rd(OFS_DATA);
		chk(rv, 32'h81);
		wr(OFS_CTRL, 32'h000);
	endtask : t_slave_receive_only_select

	initial begin
		REF_CLK     = 1'b0;
		RESETN      = 1'b0;
		REG_ADDR    = 8'h00;
		REG_WDATA   = 32'h0;
		REG_WR      = 1'b0;
		REG_RD      = 1'b0;
		miscompares = 0;
		n_tests     = 0;
		cycles      = 0;
		rv          = 32'h0;
		watch       = 1'b0;
		seen        = 1'b0;
		repeat (3) @(posedge REF_CLK);
		RESETN <= 1'b1;
		@(posedge REF_CLK);
		t_reset();
		t_master_fd();
		t_overrun();
		t_master_receive_only_select();
		t_single_tx();
		t_single_rx();
		t_slave_fd();
		t_slave_single();
		t_slave_receive_only_select();
		print_verdict();
	end
endmodule : sdm_spi_core_tb
